// ==== cec_pkg.sv ====
// Shared constants and types for the CAN error confinement block
package cec_pkg;

    // Register addresses of the host register port
    localparam logic [7:0] CEC_ADDR_TX_COUNT = 8'h1c;
    localparam logic [7:0] CEC_ADDR_RX_COUNT = 8'h1d;
    localparam logic [7:0] CEC_ADDR_FLAGS    = 8'h2d;

    // Bit positions inside the error flag register
    localparam int CEC_BIT_OVR1    = 7;
    localparam int CEC_BIT_OVR0    = 6;
    localparam int CEC_BIT_BUS_OFF = 5;
    localparam int CEC_BIT_TX_PASV = 4;
    localparam int CEC_BIT_RX_PASV = 3;
    localparam int CEC_BIT_TX_WARN = 2;
    localparam int CEC_BIT_RX_WARN = 1;
    localparam int CEC_BIT_WARN    = 0;

    // Reset values
    localparam logic [8:0] CEC_TX_COUNT_RESET = 9'h000;
    localparam logic [7:0] CEC_RX_COUNT_RESET = 8'h00;
    localparam logic [7:0] CEC_FLAGS_RESET    = 8'h00;

    // Thresholds and recovery counts
    localparam logic [8:0] CEC_WARN_LIMIT    = 9'h060;
    localparam logic [8:0] CEC_PASSIVE_LIMIT = 9'h080;
    localparam logic [8:0] CEC_BUS_OFF_LIMIT = 9'h100;
    localparam logic [3:0] CEC_RUN_BITS      = 4'hb;
    localparam logic [7:0] CEC_RUN_COUNT     = 8'h80;

    // Error confinement states
    typedef enum logic [1:0] {
        CEC_ACTIVE,
        CEC_PASSIVE,
        CEC_BUS_OFF
    } cec_state_type;

    // Per-bit events from the protocol engine
    typedef struct packed {
        logic       bit_tick;      // One sampled bus bit
        logic       bit_value;     // Sampled level, 1 is recessive
        logic       tx_inc;        // Raise transmit count
        logic [3:0] tx_inc_amount;
        logic       tx_dec;        // Lower transmit count by one
        logic       rx_inc;        // Raise receive count
        logic [3:0] rx_inc_amount;
        logic       rx_dec;        // Lower receive count by one
        logic       error_seen;    // Error detected in current frame
    } cec_event_type;

    // Host register port request
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cec_host_req_type;

endpackage

// ==== cec_threshold.sv ====
// Threshold compare of one error count against the limits
`timescale 1ns/1ps
module cec_threshold
    import cec_pkg::*;
(
    input  wire logic [8:0] count,
    output logic            warn,
    output logic            passive,
    output logic            bus_off
);

    // Limit compares
    assign warn    = count >= CEC_WARN_LIMIT;
    assign passive = count >= CEC_PASSIVE_LIMIT;
    assign bus_off = count >= CEC_BUS_OFF_LIMIT;

endmodule

// ==== cec_error_confinement.sv ====
// CAN fault confinement: error counters, error states, flag register
`timescale 1ns/1ps
module cec_error_confinement
    import cec_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire cec_event_type    event_in,
    input  wire logic [1:0]       frame_accepted,
    input  wire logic [1:0]       buffer_full,
    input  wire cec_host_req_type host_req,
    output logic [7:0]            host_rdata_reg,
    output logic                  tx_enable_reg,
    output logic                  rx_enable_reg,
    output logic                  error_frame_dominant_reg,
    output logic                  error_frame_start_reg,
    output logic                  retransmit_req_reg,
    output cec_state_type         state_reg
);

    // Saturating add of an increment to a 9-bit count
    function automatic logic [8:0] sat_add(input logic [8:0] value, input logic [3:0] amount);
        logic [9:0] sum;
        sum = {1'b0, value} + {6'h00, amount};
        sat_add = sum[9] ? 9'h1ff : sum[8:0];
    endfunction

    // Decrement stopping at zero
    function automatic logic [8:0] sat_dec(input logic [8:0] value);
        sat_dec = (value == 9'h000) ? 9'h000 : value - 9'h001;
    endfunction

    logic [8:0]    tx_count_reg;
    logic [8:0]    tx_count_next;
    logic [7:0]    rx_count_reg;
    logic [7:0]    rx_count_next;
    logic [3:0]    run_bits_reg;
    logic [3:0]    run_bits_next;
    logic [7:0]    run_count_reg;
    logic [7:0]    run_count_next;
    logic [1:0]    overflow_reg;
    logic [1:0]    overflow_next;
    cec_state_type state_next;
    logic          tx_warn;
    logic          tx_pasv;
    logic          tx_off;
    logic          rx_warn;
    logic          rx_pasv;
    logic          rx_off_unused;
    logic          recovered;
    logic          run_done;
    logic [7:0]    flags_word;
    logic [7:0]    read_word;
    logic [8:0]    rx_wide_next;

    // Threshold compares for each counter
    cec_threshold u_tx_thr (
        .count   (tx_count_reg),
        .warn    (tx_warn),
        .passive (tx_pasv),
        .bus_off (tx_off)
    );

    cec_threshold u_rx_thr (
        .count   ({1'b0, rx_count_reg}),
        .warn    (rx_warn),
        .passive (rx_pasv),
        .bus_off (rx_off_unused)
    );

    // Recessive run counting while bus-off
    assign run_done       = event_in.bit_tick && event_in.bit_value && (run_bits_reg == CEC_RUN_BITS - 4'h1);
    assign recovered      = (state_reg == CEC_BUS_OFF) && run_done
                            && (run_count_reg == CEC_RUN_COUNT - 8'h01);
    assign run_bits_next  = (state_reg != CEC_BUS_OFF) ? 4'h0 :
                            !event_in.bit_tick ? run_bits_reg :
                            !event_in.bit_value ? 4'h0 :
                            run_done ? 4'h0 : run_bits_reg + 4'h1;
    assign run_count_next = (state_reg != CEC_BUS_OFF || recovered) ? 8'h00 :
                            run_done ? run_count_reg + 8'h01 : run_count_reg;

    // Counter updates; frozen in bus-off, cleared on recovery
    assign tx_count_next = recovered ? CEC_TX_COUNT_RESET :
                           (state_reg == CEC_BUS_OFF) ? tx_count_reg :
                           event_in.tx_inc ? sat_add(tx_count_reg, event_in.tx_inc_amount) :
                           event_in.tx_dec ? sat_dec(tx_count_reg) : tx_count_reg;
    assign rx_wide_next  = event_in.rx_inc ? sat_add({1'b0, rx_count_reg}, event_in.rx_inc_amount) :
                           event_in.rx_dec ? sat_dec({1'b0, rx_count_reg}) : {1'b0, rx_count_reg};
    assign rx_count_next = recovered ? CEC_RX_COUNT_RESET :
                           (state_reg == CEC_BUS_OFF) ? rx_count_reg :
                           rx_wide_next[8] ? 8'hff : rx_wide_next[7:0];

    // State from counter levels
    assign state_next = recovered ? CEC_ACTIVE :
                        (state_reg == CEC_BUS_OFF) ? CEC_BUS_OFF :
                        tx_off ? CEC_BUS_OFF :
                        (tx_pasv || rx_pasv) ? CEC_PASSIVE :
                        CEC_ACTIVE;

    // Overflow flags: set wins over host clear
    assign overflow_next = (overflow_reg & ~((host_req.write && host_req.addr == CEC_ADDR_FLAGS)
                            ? ~host_req.wdata[CEC_BIT_OVR1:CEC_BIT_OVR0] : 2'b00))
                           | (frame_accepted & buffer_full & {2{state_reg != CEC_BUS_OFF}});

    // Flag register image
    assign flags_word = {overflow_reg,
                         state_reg == CEC_BUS_OFF,
                         tx_pasv,
                         rx_pasv,
                         tx_warn,
                         rx_warn,
                         tx_warn || rx_warn};

    // Read multiplexer; unmapped addresses read zero
    assign read_word = (host_req.addr == CEC_ADDR_TX_COUNT) ? (tx_off ? 8'hff : tx_count_reg[7:0]) :
                       (host_req.addr == CEC_ADDR_RX_COUNT) ? rx_count_reg :
                       (host_req.addr == CEC_ADDR_FLAGS) ? flags_word : 8'h00;

    // Core state registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_count_reg  <= CEC_TX_COUNT_RESET;
            rx_count_reg  <= CEC_RX_COUNT_RESET;
            run_bits_reg  <= 4'h0;
            run_count_reg <= 8'h00;
            overflow_reg  <= 2'b00;
            state_reg     <= CEC_ACTIVE;
        end
        else
        begin
            tx_count_reg  <= tx_count_next;
            rx_count_reg  <= rx_count_next;
            run_bits_reg  <= run_bits_next;
            run_count_reg <= run_count_next;
            overflow_reg  <= overflow_next;
            state_reg     <= state_next;
        end
    end

    // Protocol engine controls and host read data
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            host_rdata_reg           <= CEC_FLAGS_RESET;
            tx_enable_reg            <= 1'b1;
            rx_enable_reg            <= 1'b1;
            error_frame_dominant_reg <= 1'b1;
            error_frame_start_reg    <= 1'b0;
            retransmit_req_reg       <= 1'b0;
        end
        else
        begin
            host_rdata_reg           <= host_req.read ? read_word : host_rdata_reg;
            tx_enable_reg            <= state_next != CEC_BUS_OFF;
            rx_enable_reg            <= state_next != CEC_BUS_OFF;
            error_frame_dominant_reg <= state_next == CEC_ACTIVE;
            error_frame_start_reg    <= event_in.error_seen && state_reg != CEC_BUS_OFF;
            retransmit_req_reg       <= event_in.error_seen && state_reg != CEC_BUS_OFF;
        end
    end

    // Checks on the confinement states
    a_active_state: assert property (@(posedge clk) disable iff (reset)
        (state_reg != CEC_BUS_OFF && !tx_pasv && !rx_pasv && !tx_off) |=> state_reg == CEC_ACTIVE)
        else $error("active state not kept below passive limit");
    a_passive_state: assert property (@(posedge clk) disable iff (reset)
        (state_reg != CEC_BUS_OFF && !tx_off && (tx_pasv || rx_pasv)) |=> state_reg == CEC_PASSIVE)
        else $error("passive state not entered");
    a_bus_off_entry: assert property (@(posedge clk) disable iff (reset)
        (state_reg != CEC_BUS_OFF && tx_off) |=> state_reg == CEC_BUS_OFF)
        else $error("bus-off not entered at limit");
    a_bus_off_hold: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_BUS_OFF && !recovered) |=> state_reg == CEC_BUS_OFF)
        else $error("bus-off left without recovery");
    a_count_frozen: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_BUS_OFF && !recovered) |=> ($stable(tx_count_reg) && $stable(rx_count_reg)))
        else $error("counts moved while bus-off");

    // Checks on bus-off recovery
    a_recover_clear: assert property (@(posedge clk) disable iff (reset)
        recovered |=> (state_reg == CEC_ACTIVE && tx_count_reg == 9'h000 && rx_count_reg == 8'h00))
        else $error("recovery did not restore active and clear counts");
    a_recover_entry: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_BUS_OFF && run_count_reg == 8'h7f && run_bits_reg == 4'ha
         && event_in.bit_tick && event_in.bit_value) |=> state_reg == CEC_ACTIVE)
        else $error("last recessive run did not recover");
    a_recover_flag: assert property (@(posedge clk) disable iff (reset)
        recovered |=> !flags_word[CEC_BIT_BUS_OFF])
        else $error("bus-off flag kept after recovery");
    a_run_reset: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_BUS_OFF && event_in.bit_tick && !event_in.bit_value) |=> run_bits_reg == 4'h0)
        else $error("dominant bit did not restart the run");
    a_run_advance: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_BUS_OFF && run_done && !recovered) |=> run_count_reg == $past(run_count_reg) + 8'h01)
        else $error("completed run not counted");
    a_run_idle: assert property (@(posedge clk) disable iff (reset)
        (state_reg != CEC_BUS_OFF) |=> (run_bits_reg == 4'h0 && run_count_reg == 8'h00))
        else $error("run counters busy outside bus-off");

    // Checks on traffic and error frames
    a_frame_polarity: assert property (@(posedge clk) disable iff (reset)
        error_frame_dominant_reg == (state_reg == CEC_ACTIVE))
        else $error("error frame polarity wrong for state");
    a_active_transmit: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_ACTIVE) |-> (tx_enable_reg && rx_enable_reg))
        else $error("traffic blocked while active");
    a_passive_frames: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_PASSIVE && $past(state_reg) == CEC_PASSIVE) |-> !error_frame_dominant_reg)
        else $error("dominant error frame while passive");
    a_passive_transmit: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_PASSIVE) |-> (tx_enable_reg && !error_frame_dominant_reg))
        else $error("passive state blocks sending or sends dominant frames");
    a_bus_off_quiet: assert property (@(posedge clk) disable iff (reset)
        (state_reg == CEC_BUS_OFF && $past(state_reg) == CEC_BUS_OFF) |-> (!tx_enable_reg && !rx_enable_reg))
        else $error("traffic enabled in bus-off");
    a_tx_enable_follow: assert property (@(posedge clk) disable iff (reset)
        tx_enable_reg == (state_reg != CEC_BUS_OFF))
        else $error("transmit enable out of step with state");
    a_rx_enable_follow: assert property (@(posedge clk) disable iff (reset)
        rx_enable_reg == (state_reg != CEC_BUS_OFF))
        else $error("receive enable out of step with state");
    a_error_quiet: assert property (@(posedge clk) disable iff (reset)
        (event_in.error_seen && state_reg == CEC_BUS_OFF) |=> !(error_frame_start_reg || retransmit_req_reg))
        else $error("error frame sent while bus-off");
    a_overflow_off: assert property (@(posedge clk) disable iff (reset)
        (!overflow_reg[0] && state_reg == CEC_BUS_OFF) |=> !overflow_reg[0])
        else $error("frame accepted while bus-off");
    a_error_retry: assert property (@(posedge clk) disable iff (reset)
        (event_in.error_seen && state_reg != CEC_BUS_OFF) |=> (error_frame_start_reg && retransmit_req_reg))
        else $error("error did not start error frame and retry");
    a_error_pair: assert property (@(posedge clk) disable iff (reset)
        error_frame_start_reg == retransmit_req_reg)
        else $error("error frame and retry not paired");
    a_error_single: assert property (@(posedge clk) disable iff (reset)
        !event_in.error_seen |=> !error_frame_start_reg)
        else $error("error frame without detected error");

    // Checks on host reads and counting
    a_read_count: assert property (@(posedge clk) disable iff (reset)
        (host_req.read && host_req.addr == CEC_ADDR_RX_COUNT) |=> host_rdata_reg == $past(rx_count_reg))
        else $error("receive count read wrong");
    a_read_tx_count: assert property (@(posedge clk) disable iff (reset)
        (host_req.read && host_req.addr == CEC_ADDR_TX_COUNT)
        |=> host_rdata_reg == (($past(tx_count_reg) >= 9'h100) ? 8'hff : $past(tx_count_reg[7:0])))
        else $error("transmit count read wrong");
    a_read_hold: assert property (@(posedge clk) disable iff (reset)
        !host_req.read |=> $stable(host_rdata_reg))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
        (host_req.read && host_req.addr != CEC_ADDR_TX_COUNT && host_req.addr != CEC_ADDR_RX_COUNT
         && host_req.addr != CEC_ADDR_FLAGS) |=> host_rdata_reg == 8'h00)
        else $error("unmapped address not read as zero");
    a_tx_floor: assert property (@(posedge clk) disable iff (reset)
        (tx_count_reg == 9'h000 && event_in.tx_dec && !event_in.tx_inc) |=> tx_count_reg == 9'h000)
        else $error("transmit count wrapped below zero");
    a_rx_floor: assert property (@(posedge clk) disable iff (reset)
        (rx_count_reg == 8'h00 && event_in.rx_dec && !event_in.rx_inc) |=> rx_count_reg == 8'h00)
        else $error("receive count wrapped below zero");
    a_tx_limit: assert property (@(posedge clk) disable iff (reset)
        (state_reg != CEC_BUS_OFF && tx_count_reg == 9'h0ff && event_in.tx_inc && event_in.tx_inc_amount != 4'h0)
        |=> tx_count_reg >= 9'h100)
        else $error("transmit count did not reach bus-off limit");

    // Checks on the flag register bits
    a_warn_flag: assert property (@(posedge clk) disable iff (reset)
        flags_word[CEC_BIT_WARN] == (tx_count_reg >= 9'h060 || rx_count_reg >= 8'h60))
        else $error("combined warning wrong");
    a_tx_passive_bit: assert property (@(posedge clk) disable iff (reset)
        flags_word[CEC_BIT_TX_PASV] == (tx_count_reg >= 9'h080))
        else $error("transmit passive bit wrong");
    a_rx_passive_bit: assert property (@(posedge clk) disable iff (reset)
        flags_word[CEC_BIT_RX_PASV] == (rx_count_reg >= 8'h80))
        else $error("receive passive bit wrong");
    a_tx_warn_bit: assert property (@(posedge clk) disable iff (reset)
        flags_word[CEC_BIT_TX_WARN] == (tx_count_reg >= 9'h060))
        else $error("transmit warning bit wrong");
    a_rx_warn_bit: assert property (@(posedge clk) disable iff (reset)
        flags_word[CEC_BIT_RX_WARN] == (rx_count_reg >= 8'h60))
        else $error("receive warning bit wrong");
    a_bus_off_bit: assert property (@(posedge clk) disable iff (reset)
        (tx_count_reg >= 9'h100 && !recovered) |=> flags_word[CEC_BIT_BUS_OFF])
        else $error("bus-off bit not set at limit");

    // Checks on the overflow flags
    a_overflow_set: assert property (@(posedge clk) disable iff (reset)
        (frame_accepted[0] && buffer_full[0] && state_reg != CEC_BUS_OFF) |=> overflow_reg[0])
        else $error("overflow not set");
    a_overflow_set1: assert property (@(posedge clk) disable iff (reset)
        (frame_accepted[1] && buffer_full[1] && state_reg != CEC_BUS_OFF) |=> overflow_reg[1])
        else $error("second overflow not set");
    a_overflow_hold: assert property (@(posedge clk) disable iff (reset)
        (overflow_reg[1] && !(host_req.write && host_req.addr == CEC_ADDR_FLAGS)) |=> overflow_reg[1])
        else $error("overflow cleared without host");
    a_overflow_hold0: assert property (@(posedge clk) disable iff (reset)
        (overflow_reg[0] && !(host_req.write && host_req.addr == CEC_ADDR_FLAGS)) |=> overflow_reg[0])
        else $error("first overflow cleared without host");
    a_overflow_clear: assert property (@(posedge clk) disable iff (reset)
        (host_req.write && host_req.addr == CEC_ADDR_FLAGS && !host_req.wdata[CEC_BIT_OVR0]
         && !(frame_accepted[0] && buffer_full[0])) |=> !overflow_reg[0])
        else $error("host clear of overflow ignored");

endmodule

// ==== cec_bus_node.sv ====
// Bus node model that supplies sampled bus bits to the confinement block
`timescale 1ns/1ps
module cec_bus_node
(
    input  wire logic clk,
    output logic      bit_tick,
    output logic      bit_value
);
    initial
    begin
        bit_tick  = 1'b0;
        bit_value = 1'b0;
    end

    // Sends n bits of one level, then leaves the level inverted while idle
    task automatic send(input int n, input logic v);
        repeat (n)
        begin
            bit_tick  = 1'b1;
            bit_value = v;
            @(negedge clk);
        end
        bit_tick  = 1'b0;
        bit_value = ~v;
    endtask
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the CAN error confinement block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    import cec_pkg::*;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             tx_inc = 1'b0, rx_inc = 1'b0, tx_dec = 1'b0, rx_dec = 1'b0, err_seen = 1'b0;
    logic             p_tick, p_val;
    logic [1:0]       frame_acc = 2'b00, buf_full = 2'b00;
    cec_host_req_type req = '0;
    cec_event_type    ev;
    logic [7:0]       rdata, d;
    logic             tx_en, rx_en, dom, efs, rtx;
    cec_state_type    st;
    int               n_errors = 0, checks_done = 0, pulses;

    // Clock of 25 ns period
    always #12.5 clk = ~clk;

    // Event word from bus node and bench pulses
    assign ev = '{bit_tick: p_tick, bit_value: p_val, tx_inc: tx_inc, tx_inc_amount: 4'h1, tx_dec: tx_dec,
                  rx_inc: rx_inc, rx_inc_amount: 4'h1, rx_dec: rx_dec, error_seen: err_seen};

    cec_bus_node bus (.clk(clk), .bit_tick(p_tick), .bit_value(p_val));

    cec_error_confinement uut (.clk(clk), .reset(reset), .event_in(ev), .frame_accepted(frame_acc),
        .buffer_full(buf_full), .host_req(req), .host_rdata_reg(rdata), .tx_enable_reg(tx_en),
        .rx_enable_reg(rx_en), .error_frame_dominant_reg(dom), .error_frame_start_reg(efs),
        .retransmit_req_reg(rtx), .state_reg(st));

    // Register read, answer taken one cycle after the request
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        req.read = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.read = 1'b0;
        v = rdata;
        @(negedge clk);
    endtask

    // Register write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        req.write = 1'b1;
        req.addr  = a;
        req.wdata = v;
        @(negedge clk);
        req.write = 1'b0;
        @(negedge clk);
    endtask

    // Holds one event pulse high for n edges
    task automatic hold(ref logic s, input int n);
        s = 1'b1;
        repeat (n) @(negedge clk);
        s = 1'b0;
    endtask

    // Error detection and count of paired abort and retransmit pulses
    task automatic error_pulse(output int cnt);
        cnt = 0;
        err_seen = 1'b1;
        repeat (3)
        begin
            @(negedge clk);
            err_seen = 1'b0;
            if ({efs, rtx} === 2'b11) cnt++;
            else if ({efs, rtx} !== 2'b00) cnt += 16;
        end
    endtask

    // Bounded wait for a state
    task automatic wait_state(input cec_state_type e, input int n);
        for (int i = 0; i < n && st !== e; i++) @(negedge clk);
    endtask

    // Prints counts and verdict, ends the run
    task automatic results();
        $display("Checks: %0d, errors: %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #(25 * 6000);
        n_errors++;
        results();
    end

    // Test sequence
    initial
    begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        rd(CEC_ADDR_TX_COUNT, d); `CHK(d, 8'h00)
        rd(CEC_ADDR_RX_COUNT, d); `CHK(d, 8'h00)
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h00)
        `CHK({st, tx_en, rx_en, dom}, {CEC_ACTIVE, 3'b111})
        frame_acc = 2'b11;
        buf_full  = 2'b11;
        @(negedge clk);
        frame_acc = 2'b00;
        @(negedge clk);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'hc0)
        wr(CEC_ADDR_FLAGS, 8'hff);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'hc0)
        wr(CEC_ADDR_FLAGS, 8'h80);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h80)
        wr(CEC_ADDR_FLAGS, 8'h00);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h00)
        hold(tx_inc, 95);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h00)
        hold(tx_inc, 1);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h05)
        hold(rx_inc, 96);
        wr(CEC_ADDR_TX_COUNT, 8'h11);
        rd(CEC_ADDR_TX_COUNT, d); `CHK(d, 8'h60)
        hold(tx_dec, 1);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h03)
        hold(tx_inc, 33);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h17)
        wait_state(CEC_PASSIVE, 3);
        `CHK({st, tx_en, rx_en, dom}, {CEC_PASSIVE, 3'b110})
        rd(8'h1e, d); `CHK(d, 8'h00)
        error_pulse(pulses); `CHK(pulses, 1)
        hold(tx_inc, 127);
        wait_state(CEC_BUS_OFF, 3);
        `CHK(st, CEC_PASSIVE)
        hold(tx_inc, 1);
        wait_state(CEC_BUS_OFF, 3);
        `CHK({st, tx_en, rx_en}, {CEC_BUS_OFF, 2'b00})
        rd(CEC_ADDR_TX_COUNT, d); `CHK(d, 8'hff)
        rd(CEC_ADDR_RX_COUNT, d); `CHK(d, 8'h60)
        rd(CEC_ADDR_FLAGS, d); `CHK(d & 8'h60, 8'h20)
        error_pulse(pulses); `CHK(pulses, 0)
        frame_acc = 2'b01;
        @(negedge clk);
        frame_acc = 2'b00;
        rd(CEC_ADDR_FLAGS, d); `CHK(d & 8'h40, 8'h00)
        bus.send(10, 1'b1);
        bus.send(1, 1'b0);
        bus.send(127 * 11 + 10, 1'b1);
        wait_state(CEC_ACTIVE, 3);
        `CHK(st, CEC_BUS_OFF)
        bus.send(1, 1'b1);
        wait_state(CEC_ACTIVE, 3);
        `CHK({st, tx_en, rx_en, dom}, {CEC_ACTIVE, 3'b111})
        rd(CEC_ADDR_TX_COUNT, d); `CHK(d, 8'h00)
        rd(CEC_ADDR_RX_COUNT, d); `CHK(d, 8'h00)
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h00)
        hold(rx_inc, 8);
        hold(rx_dec, 3);
        rd(CEC_ADDR_RX_COUNT, d); `CHK(d, 8'h05)
        hold(tx_dec, 1);
        rd(CEC_ADDR_TX_COUNT, d); `CHK(d, 8'h00)
        hold(tx_inc, 100);
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h05)
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        `CHK({st, tx_en, rx_en, dom, efs, rtx}, {CEC_ACTIVE, 5'b11100})
        rd(CEC_ADDR_TX_COUNT, d); `CHK(d, 8'h00)
        rd(CEC_ADDR_FLAGS, d); `CHK(d, 8'h00)
        hold(rx_dec, 1);
        rd(CEC_ADDR_RX_COUNT, d); `CHK(d, 8'h00)
        results();
    end
endmodule
